// *** design/eic_regs.v ***
// external interrupt controller register block: flags, enables, events
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "eic_defs.vh"
module eic_regs #(
	parameter NLINES = 8
) (
	input wire clk,
	input wire rst_n,
	input wire [7:0] regAddr,
	input wire [31:0] regWdata,
	input wire regWr,
	input wire regRd,
	output reg [31:0] regRdata,
	input wire nonmaskablePin,
	input wire [NLINES-1:0] externalLinePin,
	output wire nmiReq,
	output wire lineIrqReq,
	output wire [NLINES-1:0] lineEventOut,
	output wire irqOut
);
	reg nonmaskable_flag_r;
	reg [`EIC_SENSE_W-1:0] nonmaskable_sense_select_r;
	reg [NLINES-1:0] evOutEn_r;
	reg [NLINES-1:0] irqEn_r;
	reg [NLINES-1:0] lineFlag_r;
	reg [3*NLINES-1:0] lineSense_r;
	reg [`EIC_ST_W-1:0] stat_r;
	reg [`EIC_ST_W-1:0] statEn_r;
	reg [31:0] rdNxt;
	wire nmiHit;
	wire [NLINES-1:0] lineHit;
	wire [`EIC_ST_W-1:0] statEvt;
	genvar g;

	// true when a write hits the given offset
	function wrHit;
		input [7:0] a;
		input [7:0] off;
		input w;
		begin
			wrHit = w & (a == off);
		end
	endfunction

	// nonmaskable input detector
	eic_sense_det uNmiDet (
		.clk(clk),
		.rst_n(rst_n),
		.pinIn(nonmaskablePin),
		.senseSel(nonmaskable_sense_select_r),
		.hit(nmiHit)
	);

	// one detector per external line
	generate
		for (g = 0; g < NLINES; g = g + 1) begin : gLine
			eic_sense_det uDet (
				.clk(clk),
				.rst_n(rst_n),
				.pinIn(externalLinePin[g]),
				.senseSel(lineSense_r[`EIC_SENSE_W*g +: `EIC_SENSE_W]),
				.hit(lineHit[g])
			);
		end
	endgenerate

	// nonmaskable flag: a detection in the clearing cycle wins over the clear
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nonmaskable_flag_r <= 1'h0;
		end else if (nmiHit) begin
			nonmaskable_flag_r <= 1'h1;
		end else if (wrHit(regAddr, `EIC_OFF_NONMASKABLE_FLAG, regWr) && regWdata[`EIC_NMI_BIT]) begin
			nonmaskable_flag_r <= 1'h0;
		end
	end

	// configuration registers, shared enable vector
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nonmaskable_sense_select_r <= `EIC_SENSE_NONE;
			evOutEn_r <= {NLINES{1'b0}};
			irqEn_r <= {NLINES{1'b0}};
			lineSense_r <= {3*NLINES{1'b0}};
			statEn_r <= {`EIC_ST_W{1'b0}};
		end else begin
			if (wrHit(regAddr, `EIC_OFF_NMICTL, regWr))
				nonmaskable_sense_select_r <= regWdata[`EIC_SENSE_W-1:0];
			if (wrHit(regAddr, `EIC_OFF_EVOUT, regWr))
				evOutEn_r <= regWdata[NLINES-1:0];
			// one register, two views: clear then set, never both in one cycle
			if (wrHit(regAddr, `EIC_OFF_ENCLR, regWr))
				irqEn_r <= irqEn_r & ~regWdata[NLINES-1:0];
			else if (wrHit(regAddr, `EIC_OFF_ENSET, regWr))
				irqEn_r <= irqEn_r | regWdata[NLINES-1:0];
			if (wrHit(regAddr, `EIC_OFF_SENSE, regWr))
				lineSense_r <= regWdata[3*NLINES-1:0];
			if (wrHit(regAddr, `EIC_OFF_STEN, regWr))
				statEn_r <= regWdata[`EIC_ST_W-1:0];
		end
	end

	// per-line flags, write one to clear, detection wins
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lineFlag_r <= {NLINES{1'b0}};
		end else if (wrHit(regAddr, `EIC_OFF_LFLAG, regWr)) begin
			lineFlag_r <= (lineFlag_r & ~regWdata[NLINES-1:0]) | lineHit;
		end else begin
			lineFlag_r <= lineFlag_r | lineHit;
		end
	end

	// sticky interrupt status, set beats the clear register
	assign statEvt = {|lineHit, nmiHit};
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_r <= {`EIC_ST_W{1'b0}};
		end else if (wrHit(regAddr, `EIC_OFF_STCLR, regWr)) begin
			stat_r <= (stat_r & ~regWdata[`EIC_ST_W-1:0]) | statEvt;
		end else begin
			stat_r <= stat_r | statEvt;
		end
	end

	// readback, reserved bits zero; write-only clear reads zero
	always @* begin
		rdNxt = 32'h0;
		case (regAddr)
			`EIC_OFF_NMICTL: rdNxt[`EIC_SENSE_W-1:0] = nonmaskable_sense_select_r;
			`EIC_OFF_NONMASKABLE_FLAG: rdNxt[`EIC_NMI_BIT] = nonmaskable_flag_r;
			`EIC_OFF_EVOUT: rdNxt[NLINES-1:0] = evOutEn_r;
			`EIC_OFF_ENCLR: rdNxt[NLINES-1:0] = irqEn_r;
			`EIC_OFF_ENSET: rdNxt[NLINES-1:0] = irqEn_r;
			`EIC_OFF_LFLAG: rdNxt[NLINES-1:0] = lineFlag_r;
			`EIC_OFF_SENSE: rdNxt[3*NLINES-1:0] = lineSense_r;
			`EIC_OFF_STAT: rdNxt[`EIC_ST_W-1:0] = stat_r;
			`EIC_OFF_STEN: rdNxt[`EIC_ST_W-1:0] = statEn_r;
			default: rdNxt = 32'h0;
		endcase
	end

	// read data valid only in the cycle after the strobe
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			regRdata <= 32'h0;
		else if (regRd)
			regRdata <= rdNxt;
		else
			regRdata <= 32'h0;
	end

	assign nmiReq = nonmaskable_flag_r;
	assign lineIrqReq = |(lineFlag_r & irqEn_r);
	// events follow detection: single-cycle pulses for edge senses, held high while a level sense matches
	assign lineEventOut = lineHit & evOutEn_r;
	assign irqOut = |(stat_r & statEn_r);
endmodule // eic_regs

// *** design/eic_defs.vh ***
// constants for the external interrupt controller register block
// Overview of operation
// - the nonmaskable flag at bit 0 sets when the nonmaskable input meets its sense and requests while set.
// - writing one to the nonmaskable flag clears it, writing zero leaves it.
// - reserved bits read as zero and software writes zero to them.
// - each event output enable bit passes or blocks the event of its line on every detection.
// - writing one to a bit of the enable clear register clears that line's interrupt enable.
// - writing one to a bit of the enable set register sets that line's interrupt enable.
// - set and clear registers share one enable vector and both read back its state.
// - a line flag sets when the line meets its sense and requests only if its enable is one.
// - sense codes are none, rise, fall, both, high, low, with 6 and 7 reserved.
`ifndef EIC_DEFS_VH
`define EIC_DEFS_VH
`define EIC_ADDR_W 8
`define EIC_OFF_NMICTL 8'h02
`define EIC_OFF_NONMASKABLE_FLAG 8'h03
`define EIC_OFF_EVOUT 8'h04
`define EIC_OFF_ENCLR 8'h08
`define EIC_OFF_ENSET 8'h0c
`define EIC_OFF_LFLAG 8'h10
`define EIC_OFF_SENSE 8'h18
`define EIC_OFF_STAT 8'h20
`define EIC_OFF_STCLR 8'h24
`define EIC_OFF_STEN 8'h28
`define EIC_SENSE_NONE 3'h0
`define EIC_SENSE_RISE 3'h1
`define EIC_SENSE_FALL 3'h2
`define EIC_SENSE_BOTH 3'h3
`define EIC_SENSE_HIGH 3'h4
`define EIC_SENSE_LOW 3'h5
`define EIC_SENSE_W 3
`define EIC_NMI_BIT 0
`define EIC_ST_NMI 0
`define EIC_ST_LINE 1
`define EIC_ST_W 2
`endif

// *** design/eic_sense_det.v ***
// one input sense detector: synchroniser, edge and level match
`timescale 1ns/1ps
`include "eic_defs.vh"
module eic_sense_det (
	input wire clk,
	input wire rst_n,
	input wire pinIn,
	input wire [2:0] senseSel,
	output wire hit
);
	reg sync1_r;
	reg sync2_r;
	reg prev_r;
	reg hitC;
	// two stages before any logic looks at the pin
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= 1'h0;
			sync2_r <= 1'h0;
			prev_r <= 1'h0;
		end else begin
			sync1_r <= pinIn;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end
	// sense decode, reserved codes detect nothing
	always @* begin
		case (senseSel)
			`EIC_SENSE_RISE: hitC = sync2_r & ~prev_r;
			`EIC_SENSE_FALL: hitC = ~sync2_r & prev_r;
			`EIC_SENSE_BOTH: hitC = sync2_r ^ prev_r;
			`EIC_SENSE_HIGH: hitC = sync2_r;
			`EIC_SENSE_LOW: hitC = ~sync2_r;
			default: hitC = 1'h0;
		endcase
	end
	assign hit = hitC;
endmodule // eic_sense_det

// *** dv/eic_pin_model.sv ***
// pin drivers standing in for the outside world
`timescale 1ns/1ps
module eic_pin_model (
	input wire clk,
	input wire [8:0] want,
	output reg nmiPin,
	output reg [7:0] linePin
);
	// pins move after the edge, like an async source
	always @(posedge clk) begin
		{nmiPin, linePin} <= want;
	end
endmodule // eic_pin_model

// *** dv/eic_regs_assertions.sv ***
// checker for the interrupt controller register block
`timescale 1ns/1ps
module eic_regs_chk (
	input wire clk,
	input wire rst_n,
	input wire [7:0] regAddr,
	input wire [31:0] regWdata,
	input wire regWr,
	input wire regRd,
	input wire [31:0] regRdata,
	input wire nmiReq,
	input wire lineIrqReq,
	input wire [7:0] lineEventOut
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// one idle cycle allowed between write and read back
	property p_rst; $rose(rst_n) |-> !nmiReq && !lineIrqReq && lineEventOut == 8'h00; endproperty
	property p_resv; $past(regRd && regAddr[7:4] == 4'h0 && regAddr[3:2] != 2'h0)
		|-> regRdata[31:8] == 24'h0; endproperty
	property p_nresv; $past(regRd && regAddr == 8'h03) |-> regRdata[31:1] == 31'h0; endproperty
	property p_hold; nmiReq && !(regWr && regAddr == 8'h03 && regWdata[0]) |=> nmiReq; endproperty
	property p_drop; lineIrqReq && regWr && regAddr == 8'h08 && regWdata[7:0] == 8'hff |=> !lineIrqReq; endproperty
	property p_set; (regWr && regAddr == 8'h0c) ##1 !regWr ##1 (regRd && regAddr == 8'h08)
		|=> (regRdata[7:0] & $past(regWdata[7:0], 3)) == $past(regWdata[7:0], 3); endproperty
	property p_clr; (regWr && regAddr == 8'h08) ##1 !regWr ##1 (regRd && regAddr == 8'h0c)
		|=> (regRdata[7:0] & $past(regWdata[7:0], 3)) == 8'h00; endproperty
	property p_share; (regRd && regAddr == 8'h08) ##1 !regWr ##1 (regRd && regAddr == 8'h0c)
		|=> regRdata == $past(regRdata, 2); endproperty
	a_rst: assert property (p_rst) else $error("busy after reset");
	a_resv: assert property (p_resv) else $error("reserved bits set");
	a_nresv: assert property (p_nresv) else $error("reserved bits set");
	a_hold: assert property (p_hold) else $error("flag lost");
	a_drop: assert property (p_drop) else $error("request kept");
	a_set: assert property (p_set) else $error("set failed");
	a_clr: assert property (p_clr) else $error("clear failed");
	a_share: assert property (p_share) else $error("views differ");
	cover property ($rose(nmiReq));
	cover property ($fell(lineIrqReq));
	cover property (lineEventOut[1]);
endmodule // eic_regs_chk
bind eic_regs eic_regs_chk u_eic_regs_chk (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
	.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .nmiReq(nmiReq), .lineIrqReq(lineIrqReq),
	.lineEventOut(lineEventOut));

// *** dv/tb_eic_regs.sv ***
// testbench for the interrupt controller register block
`timescale 1ns/1ps
module tb_eic_regs;
	reg clk = 0, rst_n = 0, regWr = 0, regRd = 0;
	reg [7:0] regAddr = 8'h00;
	reg [31:0] regWdata = 32'h0;
	reg [8:0] want = 9'h000;
	wire [31:0] regRdata;
	wire nmiPin, nmiReq, lineIrqReq, irqOut;
	wire [7:0] linePin, lineEventOut;
	integer n_fail = 0, compares = 0, evCnt = 0;
	eic_regs u_eic_regs (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .nonmaskablePin(nmiPin), .externalLinePin(linePin), .nmiReq(nmiReq),
		.lineIrqReq(lineIrqReq), .lineEventOut(lineEventOut), .irqOut(irqOut));
	eic_pin_model u_eic_pin_model (.clk(clk), .want(want), .nmiPin(nmiPin), .linePin(linePin));
	initial begin
		forever #10 clk = ~clk;
	end
	// line 0 events weigh 16 so one count shows both lines
	always @(posedge clk) begin
		if (rst_n) evCnt <= evCnt + lineEventOut[1] + 16 * lineEventOut[0];
	end
	task chk(input [39:0] nm, input [31:0] e, input [31:0] g);
		begin
			compares = compares + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("ERROR %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	// one-cycle strobes; #1 lets the edge's updates land
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge clk);
			regWr <= 1;
			regAddr <= a;
			regWdata <= d;
			@(posedge clk);
			regWr <= 0;
			#1;
		end
	endtask
	task rd(input [7:0] a, input [31:0] e);
		begin
			@(posedge clk);
			regRd <= 1;
			regAddr <= a;
			@(posedge clk);
			regRd <= 0;
			#1;
			chk("rdata", e, regRdata);
		end
	endtask
	// pins need sync plus model delay before a flag shows
	task pin(input [8:0] v);
		begin
			@(posedge clk);
			want <= v;
			repeat (6) @(posedge clk);
			#1;
		end
	endtask
	task end_of_test;
		begin
			$display("compares %0d n_fail %0d", compares, n_fail);
			if (n_fail == 0 && compares > 0) $display("Regression OK");
			else $display("Regression broken");
			$finish;
		end
	endtask
	initial begin
		#300000;
		n_fail = n_fail + 1;
		end_of_test;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		rd(8'h03, 0);
		rd(8'h04, 0);
		rd(8'h0c, 0);
		wr(8'h0c, 32'h000000a5);
		rd(8'h08, 32'h000000a5);
		rd(8'h0c, 32'h000000a5);
		wr(8'h08, 32'h00000021);
		rd(8'h0c, 32'h00000084);
		rd(8'h40, 0);
		$display("enable views done");
		wr(8'h18, 32'h00249249);
		pin(9'h004);
		chk("lirq", 1, lineIrqReq);
		rd(8'h10, 32'h00000004);
		wr(8'h08, 32'h000000ff);
		chk("lirq", 0, lineIrqReq);
		wr(8'h04, 32'h00000002);
		pin(9'h007);
		chk("ev", 1, evCnt);
		rd(8'h04, 32'h00000002);
		$display("line tests done");
		wr(8'h28, 1);
		wr(8'h02, 1);
		pin(9'h107);
		chk("nmi", 1, nmiReq);
		chk("irq", 1, irqOut);
		wr(8'h03, 0);
		chk("nmi", 1, nmiReq);
		wr(8'h24, 1);
		chk("irq", 0, irqOut);
		wr(8'h03, 1);
		rd(8'h03, 0);
		$display("nmi tests done");
		wr(8'h18, 32'h0000695a);
		wr(8'h10, 32'h000000ff);
		rd(8'h10, 0);
		pin(9'h010);
		rd(8'h10, 32'h00000007);
		chk("ev", 2, evCnt);
		$display("sense tests done");
		end_of_test;
	end
endmodule // tb_eic_regs
